// ===== rtl/qpsc_pkg.sv
// constants shared by the quad pot serial control block
// assumes a 100 MHz system clock and a 24-bit serial command word
package qpsc_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_CH    = 4;
  localparam int TAP_W     = 8;
  localparam int SLOT_W    = 9;
  localparam int NUM_SLOTS = 4;
  localparam int CMD_W     = 24;
  localparam int BUF_BIT   = 8;
  localparam int CNT_W     = 5;
  // ****************************************
  // command word fields
  // ****************************************
  localparam int OP_HI     = 23;
  localparam int OP_LO     = 20;
  localparam int SLOT_HI   = 19;
  localparam int SLOT_LO   = 18;
  localparam int CH_HI     = 17;
  localparam int CH_LO     = 16;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [3:0] OP_NOP      = 4'h0;
  localparam logic [3:0] OP_WR_TAP   = 4'h1;
  localparam logic [3:0] OP_RD_TAP   = 4'h2;
  localparam logic [3:0] OP_RD_SLOT  = 4'h4;
  localparam logic [3:0] OP_PROG     = 4'h5;
  localparam logic [3:0] OP_LOAD     = 4'h6;
  localparam logic [3:0] OP_SAVE     = 4'h7;
  localparam logic [3:0] OP_UP       = 4'h8;
  localparam logic [3:0] OP_DOWN     = 4'h9;
  localparam logic [3:0] OP_LOAD_ALL = 4'hA;
  // ****************************************
  // timing and reset values
  // ****************************************
  localparam int CLK_MHZ         = 100;
  localparam int NV_WRITE_US     = 5;
  localparam int NV_WRITE_CYC    = NV_WRITE_US * CLK_MHZ;
  localparam int ACCESS_CYC      = 4;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 9'h080;
  localparam logic [CMD_W-1:0]  SHIFT_RESET = 24'h000000;
  // ****************************************
  // control states
  // ****************************************
  typedef enum logic [1:0] {ST_RECALL, ST_IDLE, ST_ACCESS, ST_NVWAIT} qpsc_state_t;
endpackage : qpsc_pkg

// ===== rtl/qpsc_sync.sv
// two flip-flop level synchroniser for pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module qpsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] resetVal,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // first stage read only by second stage
  always_ff @(posedge sys_clk) begin
    meta_q  <= pinIn;
    syncOut <= reset ? resetVal : meta_q;
  end
endmodule : qpsc_sync
`default_nettype wire

// ===== rtl/qpsc_nv_array.sv
// nonvolatile slot store: four slots of nine bits per channel
// assumes one write at a time; contents survive reset
`timescale 1ns/100ps
`default_nettype none
module qpsc_nv_array #(
  parameter int WRITE_CYC = qpsc_pkg::NV_WRITE_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  // write port
  input  wire logic                       wrReq,
  input  wire logic [3:0]                 wrAddr,
  input  wire logic [qpsc_pkg::SLOT_W-1:0] wrData,
  // read port
  input  wire logic [3:0]                 rdAddr,
  output logic      [qpsc_pkg::SLOT_W-1:0] rdData,
  // write cycle in progress
  output logic                            busy
);
  localparam int TW = $clog2(WRITE_CYC + 1);

  logic [qpsc_pkg::SLOT_W-1:0] mem_q [16] = '{default: qpsc_pkg::SLOT_RESET};
  logic [TW-1:0]               timer_q;

  initial begin
    if (WRITE_CYC < 1) $error("WRITE_CYC must be at least 1");
  end

  // store word at start of cycle, refuse while busy
  always_ff @(posedge sys_clk) begin
    if (wrReq && !busy) mem_q[wrAddr] <= wrData;
  end

  // programming time counter
  always_ff @(posedge sys_clk) begin
    if (reset) timer_q <= '0;
    else if (wrReq && !busy) timer_q <= TW'(WRITE_CYC);
    else if (busy) timer_q <= timer_q - 1'b1;
  end

  assign busy   = (timer_q != '0);
  assign rdData = mem_q[rdAddr];
endmodule : qpsc_nv_array
`default_nettype wire

// ===== rtl/qpsc_serial_ctrl.sv
// serial control logic of a quad 256-tap digital potentiometer
// assumes pins arrive asynchronously; reset stands for power-up
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R1] sample data input on serial clock rise
// [R2] chip select high: output released
// [R3] deselected means standby unless programming
// [R4] chip select low: active mode
// [R5] traffic ignored until first select fall
// [R6] all command content arrives on data input
// [R7] output changes on serial clock fall
// [R8] first output bit on select fall
// [R9] output feeds next device in chain
// [R10] open-drain active-low ready on commands
// [R11] write protect blocks slot changes only
// [R12] power-up copies slot 0 to tap
// [R13] each channel has 256 tap positions
// [R14] four slots per channel, read/write
// [R15] save tap into chosen slot
// [R16] tap set directly or from slot
// [R17] wiper follows tap register
// [R18] per-channel output buffer select
// [R19] 24-bit command, msb first
// [R20] previous 24 bits shift out
// [R21] buffer bit 8 selects buffer
// [R22] slot holds nine-bit word
module qpsc_serial_ctrl #(
  parameter int NV_CYC  = qpsc_pkg::NV_WRITE_CYC,
  parameter int ACC_CYC = qpsc_pkg::ACCESS_CYC
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // serial pins
  input  wire logic                    chipSelN,
  input  wire logic                    serialClk,
  input  wire logic                    serialIn,
  output logic                         serialOut,
  output logic                         serialOutOeN,
  // ready pin, open drain
  output logic                         readyOut,
  output logic                         readyOeN,
  // write protect pin
  input  wire logic                    writeProtN,
  // channel settings
  output logic [qpsc_pkg::NUM_CH*qpsc_pkg::TAP_W-1:0] tapRegister,
  output logic [qpsc_pkg::NUM_CH-1:0]  bufferEnable,
  // power mode
  output logic                         activeMode,
  output logic                         standby
);
  localparam int CW = qpsc_pkg::CMD_W;
  localparam int AW = $clog2(ACC_CYC + 1);

  initial begin
    if (ACC_CYC < 1) $error("ACC_CYC must be at least 1");
    if (qpsc_pkg::NUM_CH != 4) $error("channel count fixed at 4");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pinSync;
  logic       csLow, sclkS, sdiS, protect;

  qpsc_sync #(.WIDTH(4)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .pinIn    ({chipSelN, serialClk, serialIn, writeProtN}),
    .resetVal (4'h9),
    .syncOut  (pinSync)
  );

  assign csLow   = ~pinSync[3];
  assign sclkS   = pinSync[2];
  assign sdiS    = pinSync[1];
  assign protect = ~pinSync[0];

  // ****************************************
  // edge detection
  // ****************************************
  logic csLowPrev_q, sclkPrev_q;
  logic csFall, csRise, sclkRise, sclkFall;

  // previous levels of synchronised pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      csLowPrev_q <= 1'b0;
      sclkPrev_q  <= 1'b0;
    end else begin
      csLowPrev_q <= csLow;
      sclkPrev_q  <= sclkS;
    end
  end

  assign csFall   = csLow && !csLowPrev_q;
  assign csRise   = !csLow && csLowPrev_q;
  assign sclkRise = sclkS && !sclkPrev_q;
  assign sclkFall = !sclkS && sclkPrev_q;

  // ****************************************
  // arming after power-up
  // ****************************************
  logic armed_q;

  // first select fall after reset arms the port
  always_ff @(posedge sys_clk) begin
    if (reset) armed_q <= 1'b0;
    else if (csFall) armed_q <= 1'b1;          // [R5]
  end

  // ****************************************
  // shift register and bit count
  // ****************************************
  logic [CW-1:0]               shift_q;
  logic [qpsc_pkg::CNT_W-1:0]  bitCnt_q;
  logic                        respLoad;
  logic [CW-1:0]               respWord;
  logic                        inFrame;

  assign inFrame = armed_q && csLow;

  // data in at serial clock rise, response load wins
  always_ff @(posedge sys_clk) begin
    if (reset) shift_q <= qpsc_pkg::SHIFT_RESET;
    else if (respLoad) shift_q <= respWord;
    else if (inFrame && sclkRise) shift_q <= {shift_q[CW-2:0], sdiS}; // [R1] [R19] [R20] [R6]
  end

  // saturating count; extra bits keep only the last 24
  always_ff @(posedge sys_clk) begin
    if (reset) bitCnt_q <= '0;
    else if (csFall) bitCnt_q <= '0;
    else if (inFrame && sclkRise && bitCnt_q != qpsc_pkg::CNT_W'(CW)) begin
      bitCnt_q <= bitCnt_q + 1'b1;
    end
  end

  // ****************************************
  // serial output, open drain
  // ****************************************
  logic sdoBit_q;

  // msb out at select fall, then at each clock fall
  always_ff @(posedge sys_clk) begin
    if (reset) sdoBit_q <= 1'b1;
    else if (csFall) sdoBit_q <= shift_q[CW-1];                 // [R8]
    else if (inFrame && sclkFall) sdoBit_q <= shift_q[CW-1];    // [R7] [R9]
  end

  // pull low only for a zero while selected
  always_ff @(posedge sys_clk) begin
    if (reset) serialOutOeN <= 1'b1;
    else serialOutOeN <= !(inFrame && !sdoBit_q);              // [R2]
  end

  assign serialOut = 1'b0;

  // ****************************************
  // command capture
  // ****************************************
  logic [CW-1:0] cmd_q;
  logic          execReq_q;

  // latch the shifted word when select rises; run it only if 24 bits came
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_q     <= '0;
      execReq_q <= 1'b0;
    end else begin
      execReq_q <= armed_q && csRise && bitCnt_q == qpsc_pkg::CNT_W'(CW);
      if (armed_q && csRise) cmd_q <= shift_q;
    end
  end

  logic [3:0]                  op;
  logic [1:0]                  cmdSlot, cmdCh;
  logic [qpsc_pkg::SLOT_W-1:0] cmdData;

  assign op      = cmd_q[qpsc_pkg::OP_HI:qpsc_pkg::OP_LO];
  assign cmdSlot = cmd_q[qpsc_pkg::SLOT_HI:qpsc_pkg::SLOT_LO];
  assign cmdCh   = cmd_q[qpsc_pkg::CH_HI:qpsc_pkg::CH_LO];
  assign cmdData = cmd_q[qpsc_pkg::SLOT_W-1:0];

  // ****************************************
  // slot store
  // ****************************************
  logic                        nvWrReq, nvBusy;
  logic [3:0]                  nvWrAddr, nvRdAddr;
  logic [qpsc_pkg::SLOT_W-1:0] nvWrData, nvRdData;

  qpsc_nv_array #(.WRITE_CYC(NV_CYC)) u_nv (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wrReq   (nvWrReq),
    .wrAddr  (nvWrAddr),
    .wrData  (nvWrData),
    .rdAddr  (nvRdAddr),
    .rdData  (nvRdData),
    .busy    (nvBusy)
  );

  // ****************************************
  // channel registers
  // ****************************************
  logic [qpsc_pkg::TAP_W-1:0]  tap_q [qpsc_pkg::NUM_CH];
  logic [qpsc_pkg::NUM_CH-1:0] buf_q;
  logic [qpsc_pkg::NUM_CH-1:0] tapWe, bufWe;
  logic [qpsc_pkg::TAP_W-1:0]  tapNew [qpsc_pkg::NUM_CH];
  logic                        bufNew;

  // ****************************************
  // control state machine
  // ****************************************
  qpsc_pkg::qpsc_state_t state_q, state_d;
  logic [AW-1:0]         accCnt_q;
  logic [1:0]            recallCh_q;
  logic                  accDone;
  logic [qpsc_pkg::SLOT_W-1:0] curWord;

  assign accDone  = (accCnt_q == '0);
  assign curWord  = {buf_q[cmdCh], tap_q[cmdCh]};
  assign nvRdAddr = (state_q == qpsc_pkg::ST_RECALL) ? {recallCh_q, 2'b00}
                                                     : {cmdCh, cmdSlot};
  assign nvWrAddr = {cmdCh, cmdSlot};

  // next state, store writes, tap loads, response
  always_comb begin
    state_d  = state_q;
    nvWrReq  = 1'b0;
    nvWrData = cmdData;
    respLoad = 1'b0;
    respWord = {cmd_q[CW-1:CW-8], 7'h00, curWord};
    tapWe    = '0;
    bufWe    = '0;
    bufNew   = 1'b0;
    for (int i = 0; i < qpsc_pkg::NUM_CH; i++) tapNew[i] = tap_q[i];
    case (state_q)
      qpsc_pkg::ST_RECALL: begin
        tapWe[recallCh_q]  = 1'b1;                              // [R12]
        bufWe[recallCh_q]  = 1'b1;
        tapNew[recallCh_q] = nvRdData[qpsc_pkg::TAP_W-1:0];
        bufNew             = nvRdData[qpsc_pkg::BUF_BIT];
        if (recallCh_q == 2'd3) state_d = qpsc_pkg::ST_IDLE;
      end
      qpsc_pkg::ST_IDLE: begin
        if (execReq_q) begin
          case (op)
            qpsc_pkg::OP_WR_TAP: begin
              tapWe[cmdCh]  = 1'b1;                            // [R16]
              tapNew[cmdCh] = cmdData[qpsc_pkg::TAP_W-1:0];
            end
            qpsc_pkg::OP_UP: begin
              tapWe[cmdCh] = 1'b1;
              if (tap_q[cmdCh] != 8'hFF) tapNew[cmdCh] = tap_q[cmdCh] + 8'h01;
            end
            qpsc_pkg::OP_DOWN: begin
              tapWe[cmdCh] = 1'b1;
              if (tap_q[cmdCh] != 8'h00) tapNew[cmdCh] = tap_q[cmdCh] - 8'h01;
            end
            qpsc_pkg::OP_PROG: begin
              nvWrReq = !protect;                               // [R11] [R14]
              state_d = protect ? qpsc_pkg::ST_IDLE : qpsc_pkg::ST_NVWAIT;
            end
            qpsc_pkg::OP_SAVE: begin
              nvWrData = curWord;                               // [R15] [R22]
              nvWrReq  = !protect;                              // [R11]
              state_d  = protect ? qpsc_pkg::ST_IDLE : qpsc_pkg::ST_NVWAIT;
            end
            qpsc_pkg::OP_RD_TAP, qpsc_pkg::OP_RD_SLOT, qpsc_pkg::OP_LOAD,
            qpsc_pkg::OP_LOAD_ALL: begin
              state_d = qpsc_pkg::ST_ACCESS;
            end
            default: state_d = qpsc_pkg::ST_IDLE;
          endcase
        end
      end
      qpsc_pkg::ST_ACCESS: begin
        if (accDone) begin
          state_d = qpsc_pkg::ST_IDLE;
          case (op)
            qpsc_pkg::OP_RD_TAP: respLoad = 1'b1;
            qpsc_pkg::OP_RD_SLOT: begin
              respLoad = 1'b1;                                  // [R14]
              respWord = {cmd_q[CW-1:CW-8], 7'h00, nvRdData};
            end
            qpsc_pkg::OP_LOAD: begin
              tapWe[cmdCh]  = 1'b1;                            // [R16]
              bufWe[cmdCh]  = 1'b1;
              tapNew[cmdCh] = nvRdData[qpsc_pkg::TAP_W-1:0];
              bufNew        = nvRdData[qpsc_pkg::BUF_BIT];     // [R21]
            end
            qpsc_pkg::OP_LOAD_ALL: begin
              state_d = qpsc_pkg::ST_RECALL;
            end
            default: state_d = qpsc_pkg::ST_IDLE;
          endcase
        end
      end
      qpsc_pkg::ST_NVWAIT: begin
        if (!nvBusy) state_d = qpsc_pkg::ST_IDLE;
      end
      default: state_d = qpsc_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) state_q <= qpsc_pkg::ST_RECALL;
    else state_q <= state_d;
  end

  // internal access delay for reads and loads
  always_ff @(posedge sys_clk) begin
    if (reset) accCnt_q <= '0;
    else if (state_q == qpsc_pkg::ST_IDLE) accCnt_q <= AW'(ACC_CYC - 1);
    else if (state_q == qpsc_pkg::ST_ACCESS && !accDone) accCnt_q <= accCnt_q - 1'b1;
  end

  // recall walks channels 0..3
  always_ff @(posedge sys_clk) begin
    if (reset) recallCh_q <= 2'd0;
    else if (state_q == qpsc_pkg::ST_RECALL) recallCh_q <= recallCh_q + 2'd1;
  end

  // ****************************************
  // per-channel tap and buffer registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < qpsc_pkg::NUM_CH; g++) begin : g_ch
      // tap value and buffer mode of one channel
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          tap_q[g] <= qpsc_pkg::SLOT_RESET[qpsc_pkg::TAP_W-1:0];
          buf_q[g] <= 1'b0;
        end else begin
          if (tapWe[g]) tap_q[g] <= tapNew[g];                   // [R13]
          if (bufWe[g]) buf_q[g] <= bufNew;                      // [R18] [R21]
        end
      end
      assign tapRegister[g*qpsc_pkg::TAP_W +: qpsc_pkg::TAP_W] = tap_q[g]; // [R17]
      assign bufferEnable[g] = buf_q[g];                                   // [R18]
    end
  endgenerate

  // ****************************************
  // ready line and power mode
  // ****************************************
  // ready pulled low once idle and programming done
  always_ff @(posedge sys_clk) begin
    if (reset) readyOeN <= 1'b1;
    else readyOeN <= !(state_d == qpsc_pkg::ST_IDLE && !nvBusy && !execReq_q); // [R10]
  end

  assign readyOut = 1'b0;

  // standby waits for a write cycle to finish
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      activeMode <= 1'b0;
      standby    <= 1'b1;
    end else begin
      activeMode <= inFrame;                                    // [R4]
      standby    <= !csLow && !nvBusy;                          // [R3]
    end
  end
endmodule : qpsc_serial_ctrl
`default_nettype wire

// ===== dv/qpsc_serial_ctrl_monitor.sv
// port checker for the quad pot serial control block
// bound to qpsc_serial_ctrl; sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module qpsc_serial_ctrl_monitor #(
  parameter int NV_CYC  = qpsc_pkg::NV_WRITE_CYC,
  parameter int ACC_CYC = qpsc_pkg::ACCESS_CYC
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // serial and ready pins
  input wire logic        chipSelN,
  input wire logic        serialClk,
  input wire logic        serialOut,
  input wire logic        serialOutOeN,
  input wire logic        readyOut,
  input wire logic        readyOeN,
  // channel settings and power mode
  input wire logic [31:0] tapRegister,
  input wire logic [3:0]  bufferEnable,
  input wire logic        activeMode,
  input wire logic        standby
);
  // longest busy stretch: slot write plus sync and access slack
  localparam int RDY_MAX = NV_CYC + ACC_CYC + 40;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_out_released: assert property (chipSelN [*5] |-> serialOutOeN)
    else $error("data out driven while deselected");
  a_active_sel: assert property (!chipSelN [*8] |-> activeMode && !standby)
    else $error("not active while selected");
  a_standby_idle: assert property ((chipSelN && !readyOeN) [*8] |-> standby && !activeMode)
    else $error("no standby while deselected and idle");
  a_mode_excl: assert property (activeMode |-> !standby)
    else $error("active and standby together");
  a_ready_bound: assert property ($rose(readyOeN) |-> ##[1:RDY_MAX] !readyOeN)
    else $error("ready not back in time");
  a_recall_ready: assert property ($fell(reset) |-> ##[1:16] !readyOeN)
    else $error("power-up recall did not finish");
  a_out_hold: assert property ((!chipSelN && serialClk) [*5] |=> $stable(serialOutOeN))
    else $error("data out moved while serial clock high");
  a_taps_steady: assert property (!chipSelN [*8] |-> $stable(tapRegister) && $stable(bufferEnable))
    else $error("tap or buffer moved during a frame");
  a_pins_od: assert property (readyOut == 1'b0 && serialOut == 1'b0)
    else $error("open-drain pin drives high");
endmodule : qpsc_serial_ctrl_monitor
bind qpsc_serial_ctrl qpsc_serial_ctrl_monitor #(.NV_CYC(NV_CYC), .ACC_CYC(ACC_CYC)) mon (
  .sys_clk(sys_clk), .reset(reset), .chipSelN(chipSelN), .serialClk(serialClk),
  .serialOut(serialOut), .serialOutOeN(serialOutOeN), .readyOut(readyOut),
  .readyOeN(readyOeN), .tapRegister(tapRegister), .bufferEnable(bufferEnable),
  .activeMode(activeMode), .standby(standby));
`default_nettype wire

// ===== dv/qpsc_spi_master.sv
// serial bus master model standing in for the microcontroller
// drives select, serial clock and data in; reads the open-drain pins
`timescale 1ns/100ps
`default_nettype none
module qpsc_spi_master (
  // clock
  input  wire logic        sys_clk,
  // board-level open-drain pins
  input  wire logic        sdoPin,
  input  wire logic        rdyPin,
  // serial pins driven
  output var  logic        chipSelN,
  output var  logic        serialClk,
  output var  logic        serialIn,
  // bits seen during the last frame
  output var  logic [23:0] rxWord
);
  // idle: deselected, serial clock parked low
  initial begin
    chipSelN  = 1'b1;
    serialClk = 1'b0;
    serialIn  = 1'b0;
    rxWord    = 24'h000000;
  end
  // one frame of nb bits, msb first, 125 ns serial clock
  task automatic frame(input logic [23:0] w, input int nb);
    int i;
    int k;
    k = 0;
    while (rdyPin !== 1'b0 && k < 4000) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    #1;
    chipSelN = 1'b0;
    serialIn = w[23];
    for (i = 0; i < nb; i++) begin
      #62.5 serialClk = 1'b1;
      rxWord = {rxWord[22:0], sdoPin};
      #62.5 serialClk = 1'b0;
      w = w << 1;
      serialIn = (i == nb - 1) ? ~serialIn : w[23];
    end
    #62.5 chipSelN = 1'b1;
  endtask : frame
endmodule : qpsc_spi_master
`default_nettype wire

// ===== dv/qpsc_serial_ctrl_bench.sv
// self-checking bench for the quad pot serial control block
// serial pins driven through the master model; notes checked after each frame
`timescale 1ns/100ps
`default_nettype none
module qpsc_serial_ctrl_bench;
  // expected state after one frame
  typedef struct packed {
    logic [23:0] rx;
    logic [23:0] m;
    logic [31:0] tap;
    logic [3:0]  bf;
  } qpsc_note_t;
  // pins and outputs
  logic        sys_clk, reset, writeProtN, chipSelN, serialClk, serialIn;
  logic        serialOut, serialOutOeN, readyOut, readyOeN, activeMode, standby;
  logic        sdoPin, rdyPin;
  logic [31:0] tapRegister;
  logic [3:0]  bufferEnable, bufM;
  logic [23:0] rxWord, prevW, mk;
  // reference state and bookkeeping
  qpsc_note_t  notes[$];
  logic [7:0]  tapM[4];
  logic [8:0]  slotM[4][4];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  event        resEv;
  // open-drain pins with pull-ups
  assign sdoPin = serialOutOeN ? 1'b1 : serialOut;
  assign rdyPin = readyOeN ? 1'b1 : readyOut;
  // ****************************************
  // design and master model
  // ****************************************
  qpsc_serial_ctrl #(.NV_CYC(50), .ACC_CYC(qpsc_pkg::ACCESS_CYC)) dut (
    .sys_clk(sys_clk), .reset(reset), .chipSelN(chipSelN), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN),
    .readyOut(readyOut), .readyOeN(readyOeN), .writeProtN(writeProtN),
    .tapRegister(tapRegister), .bufferEnable(bufferEnable),
    .activeMode(activeMode), .standby(standby));
  qpsc_spi_master mst (.sys_clk(sys_clk), .sdoPin(sdoPin), .rdyPin(rdyPin),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .rxWord(rxWord));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // power-up: reset 5 cycles, taps follow slot 0
  task automatic pwr();
    int i;
    reset = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    for (i = 0; i < 4; i++) {bufM[i], tapM[i]} = slotM[i][0];
    mk = 24'hFFFFFF;
    prevW = qpsc_pkg::SHIFT_RESET;
  endtask : pwr
  // one command frame: note expectations, send, wait for ready
  task automatic cmd(input logic [3:0] op, input logic [1:0] s, c,
                     input logic [8:0] d, input int nb);
    qpsc_note_t  nt;
    logic [23:0] w;
    int          i;
    w = {op, s, c, 7'h00, d};
    nt.rx = prevW;
    nt.m = (nb == 24) ? mk : 24'h000000;
    mk = (nb == 24) ? 24'hFFFFFF : 24'h000000;
    prevW = w;
    if (nb == 24) begin
      case (op)
        qpsc_pkg::OP_WR_TAP: tapM[c] = d[7:0];
        qpsc_pkg::OP_RD_TAP: begin
          prevW = {w[23:16], 8'h00, tapM[c]};
          mk = 24'hFFFEFF;
        end
        qpsc_pkg::OP_RD_SLOT: prevW = {w[23:16], 7'h00, slotM[c][s]};
        qpsc_pkg::OP_PROG: if (writeProtN) slotM[c][s] = d;
        qpsc_pkg::OP_LOAD: {bufM[c], tapM[c]} = slotM[c][s];
        qpsc_pkg::OP_SAVE: if (writeProtN) slotM[c][s] = {bufM[c], tapM[c]};
        qpsc_pkg::OP_UP: if (tapM[c] != 8'hFF) tapM[c]++;
        qpsc_pkg::OP_DOWN: if (tapM[c] != 8'h00) tapM[c]--;
        qpsc_pkg::OP_LOAD_ALL: for (i = 0; i < 4; i++) {bufM[i], tapM[i]} = slotM[i][0];
        default: ;
      endcase
    end
    nt.tap = {tapM[3], tapM[2], tapM[1], tapM[0]};
    nt.bf = bufM;
    notes.push_back(nt);
    mst.frame(w, nb);
    repeat (12) @(negedge sys_clk);
    i = 0;
    while (readyOeN !== 1'b0 && i < 2000) begin
      @(negedge sys_clk);
      i++;
    end
    if (readyOeN !== 1'b0) begin
      n_mismatch++;
      $display("Error readyOeN expected 0 seen %b", readyOeN);
      test_done();
    end else begin
      -> resEv;
    end
  endtask : cmd
  // ****************************************
  // result watcher
  // ****************************************
  initial begin
    qpsc_note_t nt;
    forever begin
      @(resEv);
      nt = notes.pop_front();
      cmp_count += 3;
      if ((rxWord & nt.m) !== (nt.rx & nt.m)) begin
        n_mismatch++;
        $display("Error rxWord expected %h seen %h", nt.rx & nt.m, rxWord & nt.m);
      end
      if (tapRegister !== nt.tap) begin
        n_mismatch++;
        $display("Error tapRegister expected %h seen %h", nt.tap, tapRegister);
      end
      if (bufferEnable !== nt.bf) begin
        n_mismatch++;
        $display("Error bufferEnable expected %h seen %h", nt.bf, bufferEnable);
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int c;
    reset = 1'b1;
    writeProtN = 1'b1;
    for (c = 0; c < 16; c++) slotM[c/4][c%4] = qpsc_pkg::SLOT_RESET;
    void'($urandom(32'h415E));
    pwr();
    cmd(qpsc_pkg::OP_NOP, 2'h0, 2'h0, 9'h000, 24);
    for (c = 0; c < 4; c++) cmd(qpsc_pkg::OP_WR_TAP, 2'h0, c[1:0], 9'($urandom), 24);
    for (c = 0; c < 4; c++) begin
      cmd(qpsc_pkg::OP_PROG, c[1:0], c[1:0], 9'($urandom), 24);
      cmd(qpsc_pkg::OP_RD_SLOT, c[1:0], c[1:0], 9'h000, 24);
    end
    for (c = 0; c < 4; c++) cmd(qpsc_pkg::OP_LOAD, c[1:0], c[1:0], 9'h000, 24);
    cmd(qpsc_pkg::OP_RD_TAP, 2'h0, 2'h2, 9'h000, 24);
    cmd(qpsc_pkg::OP_SAVE, 2'h3, 2'h1, 9'h000, 24);
    cmd(qpsc_pkg::OP_RD_SLOT, 2'h3, 2'h1, 9'h000, 24);
    writeProtN = 1'b0;
    cmd(qpsc_pkg::OP_PROG, 2'h3, 2'h1, 9'h155, 24);
    cmd(qpsc_pkg::OP_SAVE, 2'h2, 2'h2, 9'h000, 24);
    cmd(qpsc_pkg::OP_RD_SLOT, 2'h3, 2'h1, 9'h000, 24);
    writeProtN = 1'b1;
    cmd(qpsc_pkg::OP_WR_TAP, 2'h0, 2'h0, 9'h0FF, 24);
    cmd(qpsc_pkg::OP_UP, 2'h0, 2'h0, 9'h000, 24);
    cmd(qpsc_pkg::OP_DOWN, 2'h0, 2'h0, 9'h000, 24);
    cmd(qpsc_pkg::OP_WR_TAP, 2'h0, 2'h3, 9'h000, 24);
    cmd(qpsc_pkg::OP_DOWN, 2'h0, 2'h3, 9'h000, 24);
    cmd(qpsc_pkg::OP_WR_TAP, 2'h0, 2'h2, 9'h011, 20);
    cmd(qpsc_pkg::OP_PROG, 2'h0, 2'h1, 9'h1A5, 24);
    cmd(qpsc_pkg::OP_LOAD_ALL, 2'h0, 2'h0, 9'h000, 24);
    pwr();
    cmd(qpsc_pkg::OP_NOP, 2'h0, 2'h0, 9'h000, 24);
    // let the watcher take the last note before the verdict
    @(negedge sys_clk);
    test_done();
  end
endmodule : qpsc_serial_ctrl_bench
`default_nettype wire
